// File: logic/swc_top.sv
// Power control registers, low-power mode sequencer and wake wait.
`include "swc_cfg.svh"

module swc_top
#(
  parameter int unsigned WAIT_000_STATES = `SWC_WAIT_000,
  parameter int unsigned WAIT_001_STATES = `SWC_WAIT_001,
  parameter int unsigned WAIT_010_STATES = `SWC_WAIT_010,
  parameter int unsigned WAIT_011_STATES = `SWC_WAIT_011,
  parameter int unsigned WAIT_100_STATES = `SWC_WAIT_100
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sleep_exec_i,
  input wire logic wake_irq_i,
  output swc_pkg::swc_mode_t mode_o,
  output logic cpu_hold_o,
  output logic periph_hold_o,
  output logic watch_sample_o
);
  import swc_pkg::*;

  logic [7:0] pc1;
  logic [7:0] pc2;
  swc_mode_t state;
  swc_mode_t next_state;
  logic timer_busy;
  swc_count_t timer_remain;
  logic timer_load;
  logic [3:0] samp_cnt;
  logic [3:0] samp_lim;
  logic wr_hit;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  function automatic swc_count_t wait_states(input logic [2:0] code);
    case (code)
      3'b000: wait_states = swc_count_t'(WAIT_000_STATES);
      3'b001: wait_states = swc_count_t'(WAIT_001_STATES);
      3'b010: wait_states = swc_count_t'(WAIT_010_STATES);
      3'b011: wait_states = swc_count_t'(WAIT_011_STATES);
      3'b100: wait_states = swc_count_t'(WAIT_100_STATES);
      3'b101: wait_states = `SWC_WAIT_101;
      3'b110: wait_states = `SWC_WAIT_110;
      default: wait_states = `SWC_WAIT_111;
    endcase
  endfunction

  // Target of a sleep instruction from active or subactive operation.
  function automatic swc_mode_t sleep_target(input logic [7:0] r1, input logic [7:0] r2,
                                             input logic from_sub);
    if (r1[`SWC_PC1_STANDBY_SELECT])
      sleep_target = swc_m_standby;
    else if (r2[`SWC_PC2_DTON] && r2[`SWC_PC2_LSON] && !from_sub)
      sleep_target = swc_m_subactive;
    else if (r2[`SWC_PC2_DTON] && !r2[`SWC_PC2_LSON] && from_sub)
      sleep_target = swc_m_wait;
    else if (r2[`SWC_PC2_SMSEL] && r2[`SWC_PC2_LSON])
      sleep_target = swc_m_subsleep;
    else
      sleep_target = from_sub ? swc_m_subsleep : swc_m_sleep;
  endfunction

  // ----------------------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------------------
  assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else if (ce_i)
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  // Unmapped reads return zero; the status word is read-only.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o)
    begin
      case (wb_adr_i)
        `SWC_OFS_PC1: wb_dat_o <= {24'h000000, pc1 & ~`SWC_PC1_RSV_MASK};
        `SWC_OFS_PC2: wb_dat_o <= {24'h000000, pc2};
        `SWC_OFS_STAT: wb_dat_o <= {28'h0000000, timer_busy, state};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pc1 <= `SWC_PC1_RESET;
      pc2 <= `SWC_PC2_RESET;
    end
    else if (ce_i && wr_hit)
    begin
      if (wb_adr_i == `SWC_OFS_PC1)
        pc1 <= wb_dat_i[7:0] & ~`SWC_PC1_RSV_MASK;
      if (wb_adr_i == `SWC_OFS_PC2)
        pc2 <= wb_dat_i[7:0] & `SWC_PC2_WMASK;
    end
  end

  // ----------------------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------------------
  // A wake from plain sleep keeps the system clock running, so no wait is needed.
  always_comb
  begin
    next_state = state;
    case (state)
      swc_m_active:
        if (sleep_exec_i)
          next_state = sleep_target(pc1, pc2, 1'b0);
      swc_m_subactive:
        if (sleep_exec_i)
          next_state = sleep_target(pc1, pc2, 1'b1);
      swc_m_sleep:
        if (wake_irq_i)
          next_state = swc_m_active;
      swc_m_subsleep:
        if (wake_irq_i)
          next_state = pc2[`SWC_PC2_LSON] ? swc_m_subactive : swc_m_wait;
      swc_m_standby:
        if (wake_irq_i)
          next_state = swc_m_wait;
      swc_m_wait:
        if (timer_busy && timer_remain == 18'h00000)
          next_state = swc_m_active;
      default:
        next_state = swc_m_active;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= swc_m_active;
    else if (ce_i)
      state <= next_state;
  end

  assign timer_load = next_state == swc_m_wait && state != swc_m_wait;

  swc_wake_timer u_timer
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .load_i(timer_load),
    .load_val_i(wait_states(pc1[`SWC_PC1_WW_HI:`SWC_PC1_WW_LO])),
    .busy_o(timer_busy),
    .remain_o(timer_remain)
  );

  assign mode_o = state;
  assign cpu_hold_o = state != swc_m_active && state != swc_m_subactive;
  assign periph_hold_o = state == swc_m_standby || state == swc_m_wait;

  // ----------------------------------------------------------------------------
  // Watch clock sampling strobe
  // ----------------------------------------------------------------------------
  // The new limit applies at once; a count already past it wraps without a strobe, so a short glitch period is avoided.
  assign samp_lim = pc1[`SWC_PC1_NSEL] ? `SWC_SAMP_DIV_FAST : `SWC_SAMP_DIV_SLOW;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      samp_cnt <= 4'h0;
      watch_sample_o <= 1'b0;
    end
    else if (ce_i)
    begin
      watch_sample_o <= samp_cnt == samp_lim;
      if (samp_cnt >= samp_lim)
        samp_cnt <= 4'h0;
      else
        samp_cnt <= samp_cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_standby_entry: assert property (
    ce_i && state == swc_m_active && sleep_exec_i && pc1[`SWC_PC1_STANDBY_SELECT]
    |=> state == swc_m_standby) else $error("standby not entered");
  chk_sleep_entry: assert property (
    ce_i && state == swc_m_active && sleep_exec_i && pc1 == 8'h00 && pc2 == 8'h00
    |=> state == swc_m_sleep) else $error("sleep not entered");
  chk_subsleep_select: assert property (
    ce_i && state == swc_m_active && sleep_exec_i && !pc1[`SWC_PC1_STANDBY_SELECT]
    && pc2[`SWC_PC2_SMSEL] && pc2[`SWC_PC2_LSON] && !pc2[`SWC_PC2_DTON]
    |=> state == swc_m_subsleep) else $error("subsleep not entered");
  chk_wake_hold: assert property (
    ce_i && state == swc_m_standby && wake_irq_i
    |=> state == swc_m_wait && cpu_hold_o && periph_hold_o) else $error("wake hold missing");
  chk_wait_load: assert property (
    ce_i && timer_load
    |=> timer_busy && timer_remain == $past(wait_states(pc1[6:4])) - 18'h00001)
    else $error("wrong wait length");
  chk_hold_release: assert property (
    ce_i && state == swc_m_wait && timer_busy && timer_remain == 18'h00000
    |=> state == swc_m_active && !cpu_hold_o) else $error("hold not released");
  chk_reserved_zero: assert property (
    wb_ack_o && $past(wb_adr_i) == `SWC_OFS_PC1 |-> wb_dat_o[2:0] == 3'b000)
    else $error("reserved bits not zero");
  // The default disable would switch this check off whenever its antecedent holds.
  chk_reset_clear: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> pc1 == 8'h00 && state == swc_m_active) else $error("reset did not clear");
  chk_sample_rate: assert property (
    ce_i |=> watch_sample_o == ($past(samp_cnt) == $past(samp_lim)))
    else $error("sample strobe off rate");
  chk_ack_single: assert property (
    ce_i && wb_ack_o |=> !wb_ack_o) else $error("ack held too long");

  cov_standby_wake: cover property (state == swc_m_wait ##1 state == swc_m_active);
  cov_subsleep: cover property (state == swc_m_subsleep);
  cov_fast_sample: cover property (pc1[`SWC_PC1_NSEL] && watch_sample_o);

endmodule // swc_top

// File: logic/swc_cfg.svh
// Constants for the standby and wake control block.
// Operation
// - The standby-select bit decides which low-power mode a sleep instruction enters.
// - Standby-select 0 gives sleep, subsleep, subactive or the wait before active, by register two; 1 gives standby.
// - Waking into active mode from standby or sub modes holds CPU and peripherals.
// - Wake-wait codes 000..111 give 8192,16384,32768,65536,131072,1024,128,16 states.
// - Watch sample rate bit: 0 samples at clock/16, 1 at clock/4.
// - Reserved low bits of power control one always read zero.
// - Mode choice also uses sleep-mode, low-speed and direct-transfer bits of register two.
`ifndef SWC_CFG_SVH
`define SWC_CFG_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define SWC_OFS_PC1 32'h0000_0000
`define SWC_OFS_PC2 32'h0000_0004
`define SWC_OFS_STAT 32'h0000_0008

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define SWC_PC1_STANDBY_SELECT 7
`define SWC_PC1_WW_HI 6
`define SWC_PC1_WW_LO 4
`define SWC_PC1_NSEL 3
`define SWC_PC1_RSV_MASK 8'h07
`define SWC_PC2_SMSEL 7
`define SWC_PC2_LSON 6
`define SWC_PC2_DTON 5
`define SWC_PC2_WMASK 8'he0
`define SWC_PC1_RESET 8'h00
`define SWC_PC2_RESET 8'h00

// ----------------------------------------------------------------------------
// Timing counts in clock states
// ----------------------------------------------------------------------------
`define SWC_WAIT_000 8192
`define SWC_WAIT_001 16384
`define SWC_WAIT_010 32768
`define SWC_WAIT_011 65536
`define SWC_WAIT_100 131072
`define SWC_WAIT_101 18'h00400
`define SWC_WAIT_110 18'h00080
`define SWC_WAIT_111 18'h00010
`define SWC_SAMP_DIV_SLOW 4'hf
`define SWC_SAMP_DIV_FAST 4'h3

`endif

// File: logic/swc_pkg.sv
// Types shared by the standby and wake control block.
package swc_pkg;

  typedef enum logic [2:0]
  {
    swc_m_active = 3'b000,
    swc_m_sleep = 3'b001,
    swc_m_subactive = 3'b010,
    swc_m_subsleep = 3'b011,
    swc_m_standby = 3'b100,
    swc_m_wait = 3'b101
  } swc_mode_t;

  typedef logic [17:0] swc_count_t;

endpackage

// File: logic/swc_wake_timer.sv
// Down counter that times the clock-stabilisation wait.
module swc_wake_timer
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire swc_pkg::swc_count_t load_val_i,
  output logic busy_o,
  output swc_pkg::swc_count_t remain_o
);
  import swc_pkg::*;

  // ----------------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------------
  // Busy stays high for exactly load_val_i enabled cycles after the load.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_o <= 1'b0;
      remain_o <= 18'h00000;
    end
    else if (ce_i)
    begin
      if (load_i)
      begin
        busy_o <= 1'b1;
        remain_o <= load_val_i - 18'h00001;
      end
      else if (busy_o)
      begin
        if (remain_o == 18'h00000)
          busy_o <= 1'b0;
        else
          remain_o <= remain_o - 18'h00001;
      end
    end
  end

endmodule // swc_wake_timer

// File: bench/swc_top_tb_top.sv
// Self-checking testbench for the standby and wake control block.
`include "swc_cfg.svh"

module swc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import swc_pkg::*;

  // --------------------------------------------------------------------------
  // Stimulus and observed signals
  // --------------------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0000_0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic sleep_exec_i = 1'b0;
  logic wake_irq_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  swc_mode_t mode_o;
  logic cpu_hold_o;
  logic periph_hold_o;
  logic watch_sample_o;
  int mismatches = 0;
  int checked = 0;
  // Long waits are shortened so that all eight codes fit in one short run.
  // These shortened waits fall below the 6.5 ms floor; real software must not.
  int wait_len[8] = '{40, 48, 56, 64, 72, 1024, 128, 16};

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  swc_top #(.WAIT_000_STATES(40), .WAIT_001_STATES(48), .WAIT_010_STATES(56),
            .WAIT_011_STATES(64), .WAIT_100_STATES(72)) swc_top_i
  (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_exec_i(sleep_exec_i),
    .wake_irq_i(wake_irq_i), .mode_o(mode_o), .cpu_hold_o(cpu_hold_o),
    .periph_hold_o(periph_hold_o), .watch_sample_o(watch_sample_o)
  );

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // The request is held until ack is seen, so the master never assumes a latency.
  task automatic wb_xfer(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                         output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    chk(wb_ack_o, 1'b1, "bus ack");
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] adr, input logic [7:0] dat);
    logic [31:0] unused;
    wb_xfer(1'b1, adr, {24'h00_0000, dat}, unused);
  endtask

  task automatic rd_chk(input logic [31:0] adr, input logic [31:0] exp, input string what);
    logic [31:0] rdat;
    wb_xfer(1'b0, adr, 32'h0000_0000, rdat);
    chk(rdat, exp, what);
  endtask

  task automatic pulse(input bit wake);
    @(posedge clk_i);
    if (wake)
      wake_irq_i <= 1'b1;
    else
      sleep_exec_i <= 1'b1;
    @(posedge clk_i);
    wake_irq_i <= 1'b0;
    sleep_exec_i <= 1'b0;
    #1;
  endtask

  task automatic wait_count(input int exp_n);
    int n;
    n = 0;
    while (mode_o === swc_m_wait && n < 2000)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(n, exp_n, "wait length");
    chk({cpu_hold_o, periph_hold_o, mode_o}, {2'b00, swc_m_active}, "after wait");
  endtask

  // The third interval is taken because the first one starts partway through a count.
  task automatic meas(output int p);
    for (int k = 0; k < 3; k++)
    begin
      p = 0;
      do
      begin
        @(posedge clk_i);
        #1;
        p++;
      end
      while (watch_sample_o !== 1'b1 && p < 100);
    end
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic test_regs();
    rd_chk(`SWC_OFS_PC1, 32'h0000_0000, "pc1 reset");
    rd_chk(`SWC_OFS_PC2, 32'h0000_0000, "pc2 reset");
    chk({cpu_hold_o, periph_hold_o, mode_o}, {2'b00, swc_m_active}, "reset mode");
    wr(`SWC_OFS_PC1, 8'hff);
    rd_chk(`SWC_OFS_PC1, 32'h0000_00f8, "pc1 reserved");
    rd_chk(32'h0000_0040, 32'h0000_0000, "unmapped");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(`SWC_OFS_PC1, 32'h0000_0000, "pc1 after reset");
    $display("test_regs finished");
  endtask

  task automatic test_sleep();
    pulse(1'b0);
    chk({cpu_hold_o, periph_hold_o, mode_o}, {2'b10, swc_m_sleep}, "sleep entry");
    rd_chk(`SWC_OFS_STAT, 32'h0000_0001, "status in sleep");
    pulse(1'b1);
    chk(mode_o, swc_m_active, "sleep exit");
    $display("test_sleep finished");
  endtask

  task automatic test_wait(input logic [2:0] code);
    wr(`SWC_OFS_PC1, {1'b1, code, 4'h0});
    pulse(1'b0);
    chk({cpu_hold_o, periph_hold_o, mode_o}, {2'b11, swc_m_standby}, "standby");
    pulse(1'b1);
    chk({cpu_hold_o, periph_hold_o, mode_o}, {2'b11, swc_m_wait}, "wait hold");
    wait_count(wait_len[code]);
    $display("test_wait code %0d finished", code);
  endtask

  task automatic test_sub();
    wr(`SWC_OFS_PC1, 8'h00);
    wr(`SWC_OFS_PC2, 8'hc0);
    pulse(1'b0);
    chk(mode_o, swc_m_subsleep, "subsleep entry");
    pulse(1'b1);
    chk(mode_o, swc_m_subactive, "subactive wake");
    wr(`SWC_OFS_PC2, 8'h20);
    pulse(1'b0);
    chk(mode_o, swc_m_wait, "direct to active");
    wait_count(wait_len[0]);
    wr(`SWC_OFS_PC2, 8'h00);
    $display("test_sub finished");
  endtask

  // Ten frozen cycles stretch the wait; eleven edges pass before the count starts.
  task automatic test_freeze();
    wr(`SWC_OFS_PC1, 8'hf0);
    pulse(1'b0);
    pulse(1'b1);
    @(posedge clk_i);
    ce_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk(mode_o, swc_m_wait, "frozen wait");
    ce_i <= 1'b1;
    #1;
    wait_count(wait_len[7] + 10 - 11);
    $display("test_freeze finished");
  endtask

  task automatic test_watch();
    int p;
    wr(`SWC_OFS_PC1, 8'h00);
    meas(p);
    chk(p, 16, "slow sample period");
    wr(`SWC_OFS_PC1, 8'h08); // The bench clock lies above the 2 to 10 MHz band.
    meas(p);
    chk(p, 4, "fast sample period");
    $display("test_watch finished");
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    test_regs();
    test_sleep();
    for (int c = 0; c < 8; c++)
      test_wait(c[2:0]);
    test_sub();
    test_freeze();
    test_watch();
    finish_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    $display("ERROR at %0t: watchdog expired", $time);
    finish_test();
  end

endmodule // swc_top_tb_top
